// File: gpio_defines.svh
// How it works
// - Eight pins, numbered 0 to 7, each with its own settings and data bit.
// - Settings are per pin; one write to the group register sets all masked pins.
// - An inverted input pin reads back as the complement of its level.
// - An inverted output pin drives the complement of its output bit.
// - The bus keeper weakly pulls the pin toward the last level it carried.
// - Sense both edges, rising, falling or low level; feeds interrupts and events.
// - Sensing runs synchronised or through a short unsynchronised path.
// - Edge and level sensing look at the pin after inversion.
// - Pin changes and external pin conditions both raise port interrupts.
// - Two interrupt outputs; each pin reaches either through a mask.
// - Each interrupt has its own priority level and its own sense mask.
// - Set, clear and toggle aliases change only bits written as one.
// - Drive is totem-pole, pull-up, pull-down, wired-AND, wired-OR or bus keeper.
// - The pull-down drive mode acts only while the pin is an input.
// - The pull-up drive mode acts only while the pin is an input.
// - Wired-OR may add a pull-down.
// - Wired-AND may add a pull-up.
// - A selected pin may carry the system clock instead of its output bit.
// - A selected pin may carry event channel 7 instead of its output bit.
// - Direction, output and input also appear in a virtual port window.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define ADR_DIR      8'h00
`define ADR_DIRSET   8'h04
`define ADR_DIRCLR   8'h08
`define ADR_DIRTGL   8'h0C
`define ADR_OUT      8'h10
`define ADR_OUTSET   8'h14
`define ADR_OUTCLR   8'h18
`define ADR_OUTTGL   8'h1C
`define ADR_IN       8'h20
`define ADR_INTCTRL  8'h24
`define ADR_INT0MASK 8'h28
`define ADR_INT1MASK 8'h2C
`define ADR_INTFLAGS 8'h30
`define ADR_MPCMASK  8'h34
`define ADR_MPCCFG   8'h38
`define ADR_OUTSEL   8'h3C
`define ADR_PINCFG0  8'h40
`define ADR_PINCFG7  8'h5C
`define ADR_VDIR     8'h80
`define ADR_VOUT     8'h84
`define ADR_VIN      8'h88

// ****************************************************************
// Field positions and encodings.
// ****************************************************************
`define OUTSEL_CLK_EN 3
`define OUTSEL_EVT_EN 7
`define OUTSEL_VP_EN  8
`define SENSE_BOTH    3'h0
`define SENSE_RISE    3'h1
`define SENSE_FALL    3'h2
`define SENSE_LOW     3'h3
`define DRV_TOTEM     3'h0
`define DRV_KEEPER    3'h1
`define DRV_PULLDOWN  3'h2
`define DRV_PULLUP    3'h3
`define DRV_WOR       3'h4
`define DRV_WAND      3'h5
`define DRV_WOR_PD    3'h6
`define DRV_WAND_PU   3'h7

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_BYTE      8'h00
`define RST_WORD      32'h0000_0000
`define RST_PINCFG    8'h00
`define RST_OUTSEL    9'h000

`endif

// File: gpio_pkg.sv
`default_nettype none
package gpio_pkg;
    typedef logic [7:0] pin_vec_t;
    typedef logic [2:0] sense_sel_t;
    typedef logic [2:0] drive_sel_t;
    typedef struct packed {
        logic       async_en;
        logic       invert;
        drive_sel_t drive;
        sense_sel_t sense;
    } pin_cfg_t;
endpackage
`default_nettype wire

// File: pin_sense_if.sv
`default_nettype none
interface pin_sense_if;
    import gpio_pkg::*;
    logic       level;
    sense_sel_t sense;
    logic       async_en;
    logic       detect;
    modport port_mp  (output level, output sense, output async_en, input detect);
    modport sense_mp (input level, input sense, input async_en, output detect);
endinterface
`default_nettype wire

// File: pin_sense.sv
`include "gpio_defines.svh"
`default_nettype none
module pin_sense
    import gpio_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   srst,
    input  wire logic   ce,
    pin_sense_if.sense_mp sif
);
    logic sync1_q;
    logic sync2_q;
    logic fast_q;
    logic prev_q;
    logic cur;

    // ****************************************************************
    // Synchroniser and short path.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= sif.level;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fast_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            fast_q <= sif.level;
            prev_q <= cur;
        end
    end

    assign cur = sif.async_en ? fast_q : sync2_q;

    // ****************************************************************
    // Detector.
    // ****************************************************************
    always_comb begin
        unique case (sif.sense)
            `SENSE_BOTH: sif.detect = cur ^ prev_q;
            `SENSE_RISE: sif.detect = cur & ~prev_q;
            `SENSE_FALL: sif.detect = ~cur & prev_q;
            `SENSE_LOW:  sif.detect = ~cur;
            default:     sif.detect = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: gpio_port.sv
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`include "gpio_defines.svh"
`default_nettype none
module gpio_port
    import gpio_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [7:0]  pin_in,
    output var  logic [7:0]  pin_out,
    output var  logic [7:0]  pin_oe,
    output var  logic [7:0]  pull_up_en,
    output var  logic [7:0]  pull_down_en,
    input  wire logic        sys_clk_src,
    input  wire logic        event_ch7,
    output var  logic [7:0]  pin_event,
    output var  logic        irq0,
    output var  logic        irq1,
    output var  logic [1:0]  irq0_level,
    output var  logic [1:0]  irq1_level
);
    pin_vec_t    dir_q;
    pin_vec_t    out_q;
    pin_vec_t    in_q;
    pin_vec_t    keep_q;
    pin_vec_t    int0_mask_q;
    pin_vec_t    int1_mask_q;
    pin_vec_t    mpc_mask_q;
    logic [3:0]  intctrl_q;
    logic [1:0]  flags_q;
    logic [8:0]  outsel_q;
    pin_cfg_t    cfg_q [8];
    pin_vec_t    inv_vec;
    pin_vec_t    detect;
    pin_vec_t    out_d;
    pin_vec_t    oe_d;
    pin_vec_t    pu_d;
    pin_vec_t    pd_d;
    logic        access;
    logic        wr;
    logic        vp_en;
    logic        lane0;
    pin_vec_t    wbyte;
    logic [31:0] rdata;

    pin_sense_if sif [8] ();

    // ****************************************************************
    // Wishbone slave: answer one cycle after the request is presented.
    // ****************************************************************
    assign access = wb_cyc_i & wb_stb_i;
    assign wr     = access & wb_we_i & wb_ack_o;
    assign lane0  = wb_sel_i[0];
    assign wbyte  = wb_dat_i[7:0];
    assign vp_en  = outsel_q[`OUTSEL_VP_EN];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= access & ~wb_ack_o;
        end
    end

    always_comb begin
        rdata = `RST_WORD;
        unique case (wb_adr_i)
            `ADR_DIR, `ADR_DIRSET, `ADR_DIRCLR, `ADR_DIRTGL: rdata[7:0] = dir_q;
            `ADR_OUT, `ADR_OUTSET, `ADR_OUTCLR, `ADR_OUTTGL: rdata[7:0] = out_q;
            `ADR_IN:       rdata[7:0] = in_q;
            `ADR_INTCTRL:  rdata[3:0] = intctrl_q;
            `ADR_INT0MASK: rdata[7:0] = int0_mask_q;
            `ADR_INT1MASK: rdata[7:0] = int1_mask_q;
            `ADR_INTFLAGS: rdata[1:0] = flags_q;
            `ADR_MPCMASK:  rdata[7:0] = mpc_mask_q;
            `ADR_OUTSEL:   rdata[8:0] = outsel_q;
            `ADR_VDIR:     rdata[7:0] = vp_en ? dir_q : `RST_BYTE;
            `ADR_VOUT:     rdata[7:0] = vp_en ? out_q : `RST_BYTE;
            `ADR_VIN:      rdata[7:0] = vp_en ? in_q : `RST_BYTE;
            default: begin
                if (wb_adr_i >= `ADR_PINCFG0 && wb_adr_i <= `ADR_PINCFG7 &&
                    wb_adr_i[1:0] == 2'b00) begin
                    rdata[7:0] = cfg_q[wb_adr_i[4:2]];
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_dat_o <= `RST_WORD;
        end else if (ce && access && !wb_ack_o) begin
            wb_dat_o <= rdata;
        end
    end

    // ****************************************************************
    // Direction and output value with aliases.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dir_q <= `RST_BYTE;
        end else if (ce && wr && lane0) begin
            unique case (wb_adr_i)
                `ADR_DIR:    dir_q <= wbyte;
                `ADR_DIRSET: dir_q <= dir_q | wbyte;
                `ADR_DIRCLR: dir_q <= dir_q & ~wbyte;
                `ADR_DIRTGL: dir_q <= dir_q ^ wbyte;
                `ADR_VDIR: begin
                    if (vp_en) begin
                        dir_q <= wbyte;
                    end
                end
                default: dir_q <= dir_q;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_q <= `RST_BYTE;
        end else if (ce && wr && lane0) begin
            unique case (wb_adr_i)
                `ADR_OUT:    out_q <= wbyte;
                `ADR_OUTSET: out_q <= out_q | wbyte;
                `ADR_OUTCLR: out_q <= out_q & ~wbyte;
                `ADR_OUTTGL: out_q <= out_q ^ wbyte;
                `ADR_VOUT: begin
                    if (vp_en) begin
                        out_q <= wbyte;
                    end
                end
                default: out_q <= out_q;
            endcase
        end
    end

    // ****************************************************************
    // Control registers.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            intctrl_q   <= 4'h0;
            int0_mask_q <= `RST_BYTE;
            int1_mask_q <= `RST_BYTE;
            mpc_mask_q  <= `RST_BYTE;
            outsel_q    <= `RST_OUTSEL;
        end else if (ce && wr) begin
            if (lane0 && wb_adr_i == `ADR_INTCTRL) begin
                intctrl_q <= wbyte[3:0];
            end
            if (lane0 && wb_adr_i == `ADR_INT0MASK) begin
                int0_mask_q <= wbyte;
            end
            if (lane0 && wb_adr_i == `ADR_INT1MASK) begin
                int1_mask_q <= wbyte;
            end
            if (lane0 && wb_adr_i == `ADR_MPCMASK) begin
                mpc_mask_q <= wbyte;
            end
            if (wb_adr_i == `ADR_OUTSEL) begin
                if (lane0) begin
                    outsel_q[7:0] <= wbyte;
                end
                if (wb_sel_i[1]) begin
                    outsel_q[8] <= wb_dat_i[8];
                end
            end
        end
    end

    // ****************************************************************
    // Pin configuration, single or through the group mask.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                cfg_q[i] <= `RST_PINCFG;
            end
        end else if (ce && wr && lane0) begin
            for (int i = 0; i < 8; i++) begin
                if (wb_adr_i == `ADR_PINCFG0 + 8'(4 * i)) begin
                    cfg_q[i] <= wbyte;
                end else if (wb_adr_i == `ADR_MPCCFG && mpc_mask_q[i]) begin
                    cfg_q[i] <= wbyte;
                end
            end
        end
    end

    // ****************************************************************
    // Input sampling, sensing and interrupts.
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            inv_vec[i] = cfg_q[i].invert;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            in_q   <= `RST_BYTE;
            keep_q <= `RST_BYTE;
        end else if (ce) begin
            in_q   <= pin_in ^ inv_vec;
            keep_q <= pin_in;
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_sense
        assign sif[g].level    = pin_in[g] ^ cfg_q[g].invert;
        assign sif[g].sense    = cfg_q[g].sense;
        assign sif[g].async_en = cfg_q[g].async_en;
        assign detect[g]       = sif[g].detect;
        pin_sense u_sense (
            .core_clk (core_clk),
            .srst     (srst),
            .ce       (ce),
            .sif      (sif[g])
        );
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_event <= `RST_BYTE;
        end else if (ce) begin
            pin_event <= detect;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags_q <= 2'b00;
        end else if (ce) begin
            for (int k = 0; k < 2; k++) begin
                if (|(detect & (k == 0 ? int0_mask_q : int1_mask_q))) begin
                    flags_q[k] <= 1'b1;
                end else if (wr && lane0 && wb_adr_i == `ADR_INTFLAGS && wbyte[k]) begin
                    flags_q[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq0       <= 1'b0;
            irq1       <= 1'b0;
            irq0_level <= 2'b00;
            irq1_level <= 2'b00;
        end else if (ce) begin
            irq0       <= flags_q[0] & (intctrl_q[1:0] != 2'b00);
            irq1       <= flags_q[1] & (intctrl_q[3:2] != 2'b00);
            irq0_level <= intctrl_q[1:0];
            irq1_level <= intctrl_q[3:2];
        end
    end

    // ****************************************************************
    // Output stage.
    // ****************************************************************
    always_comb begin
        logic v;
        v = 1'b0;
        for (int i = 0; i < 8; i++) begin
            v = out_q[i];
            if (outsel_q[`OUTSEL_CLK_EN] && outsel_q[2:0] == 3'(i)) begin
                v = sys_clk_src;
            end else if (outsel_q[`OUTSEL_EVT_EN] && outsel_q[6:4] == 3'(i)) begin
                v = event_ch7;
            end
            v     = v ^ cfg_q[i].invert;
            out_d[i] = v;
            oe_d[i]  = dir_q[i];
            pu_d[i]  = 1'b0;
            pd_d[i]  = 1'b0;
            unique case (cfg_q[i].drive)
                `DRV_TOTEM: begin
                end
                `DRV_KEEPER: begin
                    pu_d[i] = ~dir_q[i] & keep_q[i];
                    pd_d[i] = ~dir_q[i] & ~keep_q[i];
                end
                `DRV_PULLDOWN: pd_d[i] = ~dir_q[i];
                `DRV_PULLUP:   pu_d[i] = ~dir_q[i];
                `DRV_WOR, `DRV_WOR_PD: begin
                    out_d[i] = 1'b1;
                    oe_d[i]  = dir_q[i] & v;
                    pd_d[i]  = cfg_q[i].drive == `DRV_WOR_PD;
                end
                `DRV_WAND, `DRV_WAND_PU: begin
                    out_d[i] = 1'b0;
                    oe_d[i]  = dir_q[i] & ~v;
                    pu_d[i]  = cfg_q[i].drive == `DRV_WAND_PU;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_out      <= `RST_BYTE;
            pin_oe       <= `RST_BYTE;
            pull_up_en   <= `RST_BYTE;
            pull_down_en <= `RST_BYTE;
        end else if (ce) begin
            pin_out      <= out_d;
            pin_oe       <= oe_d;
            pull_up_en   <= pu_d;
            pull_down_en <= pd_d;
        end
    end
endmodule
`default_nettype wire

// File: gpio_pins_model.sv
`default_nettype none
module gpio_pins_model
    import gpio_pkg::*;
(
    input  wire logic     core_clk,
    input  wire pin_vec_t pin_out,
    input  wire pin_vec_t pin_oe,
    input  wire pin_vec_t pull_up_en,
    input  wire pin_vec_t pull_down_en,
    input  wire pin_vec_t ext_drv,
    input  wire pin_vec_t ext_en,
    output var  pin_vec_t level
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Board side of each pin: port drive, board drive, pulls, or floating.
    // ****************************************************************
    pin_vec_t float_q = 8'h00;
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_drv[i];
            end else if (pull_up_en[i]) begin
                level[i] = 1'b1;
            end else if (pull_down_en[i]) begin
                level[i] = 1'b0;
            end else begin
                level[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: gpio_port_checker.sv
`include "gpio_defines.svh"
`default_nettype none
module gpio_port_checker (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [7:0]  pin_oe,
    input  wire logic [7:0]  pull_up_en,
    input  wire logic [7:0]  pull_down_en,
    input  wire logic        irq0,
    input  wire logic        irq1,
    input  wire logic [1:0]  irq0_level,
    input  wire logic [1:0]  irq1_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Bus handshake, reset, pulls and interrupt level checks.
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic       req;
    logic       lvl_hit;
    logic [3:0] lvl_q;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    assign lvl_hit = req && wb_we_i && wb_adr_i == `ADR_INTCTRL && wb_sel_i[0];
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lvl_q <= 4'h0;
        end else if (lvl_hit) begin
            lvl_q <= wb_dat_i[3:0];
        end
    end
    AST_ACK_ANSWER: assert property (req |=> wb_ack_o)
        else $error("Request was not answered in one cycle.");
    AST_ACK_PULSE: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("Acknowledge lasted more than one cycle.");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("Acknowledge without a request.");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        srst && ce |=> pin_oe == 8'h00 && !irq0 && !irq1 && !wb_ack_o)
        else $error("Outputs active after reset.");
    AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == 8'h00)
        else $error("Pull-up and pull-down on the same pin.");
    AST_IRQ0_LEVEL: assert property (irq0 |-> irq0_level != 2'h0)
        else $error("Interrupt 0 raised at level zero.");
    AST_IRQ1_LEVEL: assert property (irq1 |-> irq1_level != 2'h0)
        else $error("Interrupt 1 raised at level zero.");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:9] == 23'h00_0000)
        else $error("Read data upper bits not zero.");
    AST_UNMAPPED: assert property (req && wb_adr_i == 8'hF0 |=> wb_dat_o == 32'h0000_0000)
        else $error("Unmapped address read nonzero.");
    AST_LEVEL_WRITE: assert property (lvl_hit |-> ##[2:3] {irq1_level, irq0_level} == lvl_q)
        else $error("Interrupt levels do not follow the control write.");
endmodule
bind gpio_port gpio_port_checker u_gpio_port_checker (.core_clk, .srst, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_oe,
    .pull_up_en, .pull_down_en, .irq0, .irq1, .irq0_level, .irq1_level);
`default_nettype wire

// File: tb.sv
`include "gpio_defines.svh"
`default_nettype none
module tb
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, srst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        sys_clk_src, event_ch7, irq0, irq1, any_ev, last_ev;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdata;
    logic [1:0]  irq0_level, irq1_level;
    pin_vec_t    pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, pin_event, ext_drv, ext_en;
    int          bad_count, tests_run, n;
    logic [10:0] tab [7] = '{11'h006, 11'h00C, 11'h012, 11'h01F, 11'h20A, 11'h40C, 11'h020};
    gpio_port u_gpio_port (.core_clk, .srst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .pin_out, .pin_oe, .pull_up_en,
        .pull_down_en, .sys_clk_src, .event_ch7, .pin_event, .irq0, .irq1, .irq0_level,
        .irq1_level);
    gpio_pins_model u_gpio_pins_model (.core_clk, .pin_out, .pin_oe, .pull_up_en,
        .pull_down_en, .ext_drv, .ext_en, .level(pin_in));
    // ****************************************************************
    // Bus access, comparison and closing tasks.
    // ****************************************************************
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d.", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) begin
            bad_count++;
            wrap_up();
        end
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
        xfer(a, 1'b1, d, s);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000, 4'hF);
        chk("register", rdata, e);
    endtask
    task automatic pause(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task automatic watch;
        any_ev = 1'b0;
        repeat (8) begin
            @(posedge core_clk);
            any_ev = any_ev | pin_event[0];
        end
        last_ev = pin_event[0];
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {srst, ce} = 2'b11;
        {wb_cyc_i, wb_stb_i, wb_we_i, sys_clk_src, event_ch7} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        ext_drv = 8'h00;
        ext_en = 8'hFF;
        pause(12);
        srst <= 1'b0;
        pause(1);
        foreach (tab[i]) rdc(8'h00 + 8'(i * 4), 32'h0000_0000);
        rdc(`ADR_OUTSEL, 32'h0000_0000);
        for (int b = 0; b < 32; b += 16) begin
            wr(8'(b), 32'h0000_00F0);
            wr(8'(b + 4), 32'h0000_000F);
            rdc(8'(b), 32'h0000_00FF);
            wr(8'(b + 8), 32'h0000_0081);
            rdc(8'(b), 32'h0000_007E);
            wr(8'(b + 12), 32'h0000_00FF);
            rdc(8'(b + 4), 32'h0000_0081);
        end
        wr(`ADR_OUT, 32'h0000_00A5);
        wr(`ADR_DIR, 32'h0000_00FF);
        wr(`ADR_MPCMASK, 32'h0000_000F);
        wr(`ADR_MPCCFG, 32'h0000_0040);
        rdc(`ADR_PINCFG0, 32'h0000_0040);
        rdc(`ADR_PINCFG7, 32'h0000_0000);
        pause(2);
        chk("pin_out", 32'(pin_out), 32'h0000_00AA);
        chk("pin_oe", 32'(pin_oe), 32'h0000_00FF);
        ext_drv <= 8'h3C;
        wr(`ADR_DIR, 32'h0000_0000);
        pause(2);
        rdc(`ADR_IN, 32'h0000_0033);
        ext_drv <= 8'h01;
        wr(`ADR_MPCMASK, 32'h0000_00FF);
        wr(`ADR_MPCCFG, 32'h0000_0000);
        wr(`ADR_OUT, 32'h0000_0001);
        for (int d = 0; d < 8; d++) begin
            wr(`ADR_PINCFG0, 32'(d * 8));
            wr(`ADR_DIRSET, 32'h0000_0001);
            pause(2);
            chk("drive oe", 32'(pin_oe[0]), 32'(d != 5 && d != 7));
            chk("drive out", 32'(pin_out[0]), 32'(d != 5 && d != 7));
            chk("pull off", 32'(pull_up_en[0] | pull_down_en[0]), 32'(d > 5));
            wr(`ADR_DIRCLR, 32'h0000_0001);
            pause(2);
            if (d < 6) chk("pull up", 32'(pull_up_en[0]), 32'(d == 1 || d == 3));
            if (d < 6) chk("pull down", 32'(pull_down_en[0]), 32'(d == 2));
        end
        ext_drv <= 8'h00;
        foreach (tab[i]) begin
            wr(`ADR_PINCFG0, 32'(tab[i][10:3]));
            pause(6);
            ext_drv[0] <= 1'b1;
            watch();
            chk("sense rise", 32'(any_ev), 32'(tab[i][2]));
            ext_drv[0] <= 1'b0;
            watch();
            chk("sense fall", 32'(any_ev), 32'(tab[i][1]));
            chk("sense level", 32'(last_ev), 32'(tab[i][0]));
        end
        wr(`ADR_PINCFG0, 32'h0000_0000);
        wr(`ADR_INT0MASK, 32'h0000_0001);
        wr(`ADR_INT1MASK, 32'h0000_0002);
        wr(`ADR_INTCTRL, 32'h0000_0009);
        wr(`ADR_INTFLAGS, 32'h0000_0003);
        chk("levels", 32'({irq1_level, irq0_level}), 32'h0000_0009);
        ext_drv[0] <= 1'b1;
        n = 0;
        while (irq0 !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            wrap_up();
        end
        chk("irq1", 32'(irq1), 32'h0000_0000);
        rdc(`ADR_INTFLAGS, 32'h0000_0001);
        wr(`ADR_INTFLAGS, 32'h0000_0001);
        pause(2);
        chk("irq0", 32'(irq0), 32'h0000_0000);
        ext_drv[1] <= 1'b1;
        pause(8);
        chk("irq1", 32'(irq1), 32'h0000_0001);
        wr(`ADR_OUT, 32'h0000_0000);
        wr(`ADR_DIR, 32'h0000_0024);
        wr(`ADR_OUTSEL, 32'h0000_00DA);
        {sys_clk_src, event_ch7} <= 2'b11;
        pause(4);
        chk("alt out", 32'(pin_out & 8'h24), 32'h0000_0024);
        {sys_clk_src, event_ch7} <= 2'b00;
        pause(4);
        chk("alt out", 32'(pin_out & 8'h24), 32'h0000_0000);
        rdc(`ADR_VDIR, 32'h0000_0000);
        wr(`ADR_OUTSEL, 32'h0000_01DA, 4'h3);
        rdc(`ADR_VDIR, 32'h0000_0024);
        wr(`ADR_VOUT, 32'h0000_0055);
        rdc(`ADR_OUT, 32'h0000_0055);
        wr(8'hF0, 32'h0000_00FF);
        rdc(8'hF0, 32'h0000_0000);
        sys_clk_src <= 1'b1;
        ce <= 1'b0;
        pause(4);
        chk("frozen clk out", 32'(pin_out[2]), 32'h0000_0000);
        ce <= 1'b1;
        pause(4);
        chk("clk out", 32'(pin_out[2]), 32'h0000_0001);
        sys_clk_src <= 1'b0;
        wrap_up();
    end
endmodule
`default_nettype wire
